// ==== include/uete_consts.vh ====
// Constants for the USB endpoint transaction engine: offsets, fields, codes.
`ifndef UETE_CONSTS_VH
`define UETE_CONSTS_VH
// ==========================================================================
// Register offsets
`define UETE_A_CTRL      4'h0
`define UETE_A_STATUS    4'h1
`define UETE_A_NAKTOG    4'h2
`define UETE_A_CNT_LO    4'h3
`define UETE_A_CNT_HI    4'h4
`define UETE_A_FIFO      4'h5
`define UETE_A_EP_IE     4'h6
`define UETE_A_GLOBAL    4'h7
`define UETE_A_GLOB_IE   4'h8
`define UETE_A_FRAME_LO  4'h9
`define UETE_A_FRAME_HI  4'ha
`define UETE_A_FIFO_RST  4'hb
// ==========================================================================
// Control register fields
`define UETE_C_ENABLE    0
`define UETE_C_ISO       1
`define UETE_C_PINGPONG  2
`define UETE_C_CONTROL   3
// ==========================================================================
// Endpoint status fields, also the endpoint interrupt enable layout
`define UETE_S_RX0       0
`define UETE_S_TXDONE    1
`define UETE_S_SETUP     2
`define UETE_S_STALL_REQUEST   3
`define UETE_S_TX_PACKET_READY     4
`define UETE_S_STALL_OR_CRC_FLAG    5
`define UETE_S_RX1       6
`define UETE_S_DIR       7
`define UETE_E_NAK_IN_FLAG     3
`define UETE_E_NAK_OUT_FLAG    4
// NAK and toggle register fields
`define UETE_N_NAK_IN_FLAG     0
`define UETE_N_NAK_OUT_FLAG    1
`define UETE_N_TOGGLE    2
// Global event register fields, also its enable layout
`define UETE_G_SOF       0
`define UETE_G_EOR       1
`define UETE_G_FRAME_CRC_GOOD     2
`define UETE_G_CRCBAD    3
// ==========================================================================
// Token packet identifiers and handshake codes
`define UETE_PID_OUT     4'h1
`define UETE_PID_IN      4'h9
`define UETE_PID_SOF     4'h5
`define UETE_PID_SETUP   4'hd
`define UETE_HS_ACK      2'h0
`define UETE_HS_NAK      2'h1
`define UETE_HS_STALL    2'h2
// Reset values
`define UETE_RST_BYTE    8'h00
`endif

// ==== rtl/uete_endpoint.v ====
// Endpoint transaction engine of a full-speed USB device, one endpoint, two banks.
`timescale 1ns/1ps
`include "uete_consts.vh"
module uete_endpoint #(
  parameter AW = 6                          // Bank address width, 64 bytes.
) (
  input  wire        i_clk_sys,             // System clock, 200 MHz.
  input  wire        i_reset,               // Synchronous reset, active high.
  input  wire [3:0]  i_addr,                // Register address.
  input  wire [7:0]  i_wdata,               // Register write data.
  input  wire        i_wr,                  // Register write strobe.
  input  wire        i_rd,                  // Register read strobe.
  output reg  [7:0]  o_rdata,               // Read data, cycle after strobe.
  input  wire        i_tok_valid,           // Token received for this endpoint.
  input  wire [3:0]  i_tok_pid,             // Token packet identifier.
  input  wire        i_rx_valid,            // Received data byte strobe.
  input  wire [7:0]  i_rx_byte,             // Received data byte.
  input  wire        i_rx_end,              // End of data packet.
  input  wire        i_rx_crc_ok,           // Data packet CRC good.
  input  wire        i_rx_data1,            // Data packet was DATA1.
  input  wire        i_sof,                 // Start of frame packet seen.
  input  wire [10:0] i_frame_num,           // Frame number of that packet.
  input  wire        i_sof_crc_ok,          // Frame packet CRC good.
  input  wire        i_bus_reset_end,       // End of bus reset seen.
  input  wire        i_host_ack,            // Host acknowledged an IN packet.
  output reg         o_hs_valid,            // Handshake request pulse.
  output reg  [1:0]  o_hs_code,             // Handshake kind.
  output reg         o_tx_valid,            // Transmit byte valid.
  output reg  [7:0]  o_tx_byte,             // Transmit byte.
  output reg         o_tx_last,             // Last byte of the packet.
  output reg         o_tx_empty,            // Packet has no data bytes.
  output reg         o_tx_data1,            // Packet goes out as DATA1.
  input  wire        i_tx_ready,            // Transmitter takes the byte.
  output wire        o_usb_irq              // Interrupt request, active high.
);
  localparam DEPTH = 1 << AW;
  localparam CW    = 11;
  localparam ST_IDLE = 4'b0001;
  localparam ST_RX   = 4'b0010;
  localparam ST_TX   = 4'b0100;
  localparam ST_ACK  = 4'b1000;

  // ========================================================================
  // State
  reg  [7:0]    rx_mem [0:2*DEPTH-1];
  reg  [7:0]    tx_mem [0:2*DEPTH-1];
  reg  [3:0]    state;
  reg  [3:0]    ctrl;
  reg  [1:0]    rx_full;
  reg           rx_bank;                    // Bank the next packet lands in.
  reg           rd_bank;                    // Bank firmware reads.
  reg  [CW-1:0] rx_cnt;
  reg  [CW-1:0] rx_count;
  reg  [AW-1:0] rd_ptr;
  reg           is_setup;
  reg  [1:0]    tx_rdy;
  reg  [CW-1:0] tx_len [0:1];
  reg           wr_bank;                    // Bank firmware fills.
  reg           tx_bank;                    // Bank the next IN sends.
  reg  [CW-1:0] wr_cnt;
  reg  [CW-1:0] tx_ptr;
  reg           tx_done;
  reg           setup_flag;
  reg           stall_rq;
  reg           stall_crc;
  reg           dir;
  reg           nak_in;
  reg           nak_out;
  reg           toggle;
  reg           tx_tog;
  reg  [6:0]    ep_ie;
  reg  [3:0]    glob;
  reg  [1:0]    glob_ie;
  reg  [10:0]   frame;
  wire          clr_all = i_reset | i_bus_reset_end;
  wire          wr_st   = i_wr && (i_addr == `UETE_A_STATUS);
  wire          wr_nak  = i_wr && (i_addr == `UETE_A_NAKTOG);
  wire          wr_gl   = i_wr && (i_addr == `UETE_A_GLOBAL);
  wire          fifo_rst = i_wr && (i_addr == `UETE_A_FIFO_RST);
  wire          iso     = ctrl[`UETE_C_ISO];
  wire          pp      = ctrl[`UETE_C_PINGPONG];
  wire          ep_on   = ctrl[`UETE_C_ENABLE];
  wire          bank_free = ~rx_full[rx_bank];
  wire          rx_done = (state == ST_RX) && i_rx_end;
  wire          rx_take = rx_done && bank_free && (iso || i_rx_crc_ok);
  wire          tx_fire = (state == ST_TX) && o_tx_valid && i_tx_ready && o_tx_last;
  wire          in_tok  = (state == ST_IDLE) && i_tok_valid && ep_on &&
                          (i_tok_pid == `UETE_PID_IN);
  wire          in_send = in_tok && !stall_rq && tx_rdy[tx_bank];
  wire          in_done = (tx_fire && iso) || ((state == ST_ACK) && i_host_ack);
  wire          pop     = i_rd && (i_addr == `UETE_A_FIFO);
  wire          push    = i_wr && (i_addr == `UETE_A_FIFO);
  wire          rdy_set = wr_st && i_wdata[`UETE_S_TX_PACKET_READY] && !tx_rdy[wr_bank];
  wire          clr_rx0 = wr_st && !i_wdata[`UETE_S_RX0] && rx_full[0];
  wire          clr_rx1 = wr_st && !i_wdata[`UETE_S_RX1] && rx_full[1];
  wire          rx_set0 = rx_take && !is_setup && (rx_bank == 1'b0);
  wire          rx_set1 = rx_take && !is_setup && (rx_bank == 1'b1);
  wire          setup_ok = rx_take && is_setup;
  wire          hs_stall = (rx_done && stall_rq && !is_setup && !iso) ||
                           (in_tok && stall_rq);
  wire          nak_o   = rx_done && !iso && !stall_rq && !bank_free && !is_setup;
  wire          nak_i   = in_tok && !iso && !stall_rq && !tx_rdy[tx_bank];

  // ========================================================================
  // Sequencer for tokens, received data and transmitted data
  always @(posedge i_clk_sys) begin
    if (clr_all || fifo_rst) begin
      state      <= ST_IDLE;
      rx_cnt     <= {CW{1'b0}};
      tx_ptr     <= {CW{1'b0}};
      is_setup   <= 1'b0;
      o_hs_valid <= 1'b0;
      o_hs_code  <= `UETE_HS_ACK;
      o_tx_valid <= 1'b0;
      o_tx_byte  <= `UETE_RST_BYTE;
      o_tx_last  <= 1'b0;
      o_tx_empty <= 1'b0;
      o_tx_data1 <= 1'b0;
    end else begin
      o_hs_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_tok_valid && ep_on &&
              (i_tok_pid == `UETE_PID_OUT || i_tok_pid == `UETE_PID_SETUP)) begin
            state    <= ST_RX;
            rx_cnt   <= {CW{1'b0}};
            is_setup <= (i_tok_pid == `UETE_PID_SETUP) && ctrl[`UETE_C_CONTROL];
          end else if (in_send) begin
            state      <= ST_TX;
            tx_ptr     <= {CW{1'b0}};
            o_tx_valid <= 1'b1;
            o_tx_byte  <= tx_mem[{tx_bank, {AW{1'b0}}}];
            o_tx_empty <= (tx_len[tx_bank] == {CW{1'b0}});
            o_tx_last  <= (tx_len[tx_bank] <= {{(CW-1){1'b0}}, 1'b1});
            o_tx_data1 <= iso ? 1'b0 : tx_tog;
          end else if (in_tok && !iso) begin
            o_hs_valid <= 1'b1;
            o_hs_code  <= stall_rq ? `UETE_HS_STALL : `UETE_HS_NAK;
          end
        end
        ST_RX: begin
          // Each byte is judged against the flag as it arrives, so a clear
          // in mid-packet keeps only the bytes that follow it.
          if (i_rx_valid && bank_free) begin
            rx_cnt <= rx_cnt + {{(CW-1){1'b0}}, 1'b1};
          end
          if (rx_done) begin
            state <= ST_IDLE;
            if (!iso && (i_rx_crc_ok || stall_rq)) begin
              // A SETUP into a full bank on a control endpoint stays silent.
              o_hs_valid <= hs_stall | nak_o | rx_take;
              o_hs_code  <= hs_stall ? `UETE_HS_STALL :
                            (nak_o ? `UETE_HS_NAK : `UETE_HS_ACK);
            end
          end
        end
        ST_TX: begin
          if (o_tx_valid && i_tx_ready) begin
            if (o_tx_last) begin
              o_tx_valid <= 1'b0;
              state      <= iso ? ST_IDLE : ST_ACK;
            end else begin
              tx_ptr    <= tx_ptr + {{(CW-1){1'b0}}, 1'b1};
              o_tx_byte <= tx_mem[{tx_bank, tx_ptr[AW-1:0] + {{(AW-1){1'b0}}, 1'b1}}];
              o_tx_last <= (tx_ptr + {{(CW-2){1'b0}}, 2'b10} >= tx_len[tx_bank]);
            end
          end
        end
        ST_ACK: begin
          // A new token means the host gave up on this packet.
          if (i_host_ack || i_tok_valid) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Receive and transmit storage; excess received bytes beyond one bank are counted, not stored
  always @(posedge i_clk_sys) begin
    if ((state == ST_RX) && i_rx_valid && bank_free && (rx_cnt < DEPTH)) begin
      rx_mem[{rx_bank, rx_cnt[AW-1:0]}] <= i_rx_byte;
    end
    if (push && (wr_cnt < DEPTH)) begin
      tx_mem[{wr_bank, wr_cnt[AW-1:0]}] <= i_wdata;
    end
  end

  // ========================================================================
  // Endpoint status, banks and counters
  always @(posedge i_clk_sys) begin
    if (clr_all || fifo_rst) begin
      rx_full    <= 2'b00;
      rx_bank    <= 1'b0;
      rd_bank    <= 1'b0;
      rd_ptr     <= {AW{1'b0}};
      rx_count   <= {CW{1'b0}};
      tx_rdy     <= 2'b00;
      wr_bank    <= 1'b0;
      tx_bank    <= 1'b0;
      wr_cnt     <= {CW{1'b0}};
      tx_len[0]  <= {CW{1'b0}};
      tx_len[1]  <= {CW{1'b0}};
      tx_done    <= 1'b0;
      setup_flag <= 1'b0;
      stall_crc  <= 1'b0;
      toggle     <= 1'b0;
      tx_tog     <= 1'b0;
      if (clr_all) begin
        stall_rq <= 1'b0;
        dir      <= 1'b0;
        nak_in   <= 1'b0;
        nak_out  <= 1'b0;
        ctrl     <= 4'h0;
        ep_ie    <= 7'h00;
      end
    end else if (setup_ok) begin
      // SETUP wipes the other status bits and restarts toggling.
      setup_flag <= 1'b1;
      rx_full    <= 2'b00;
      tx_rdy     <= 2'b00;
      tx_done    <= 1'b0;
      stall_crc  <= 1'b0;
      stall_rq   <= 1'b0;
      dir        <= 1'b0;
      rx_count   <= rx_cnt;
      rd_bank    <= 1'b0;
      rd_ptr     <= {AW{1'b0}};
      toggle     <= ~i_rx_data1;
      tx_tog     <= 1'b1;
    end else begin
      // Hardware sets win over a firmware clear in the same cycle.
      rx_full[0] <= rx_set0 | (rx_full[0] & ~clr_rx0);
      rx_full[1] <= rx_set1 | (rx_full[1] & ~clr_rx1);
      if (rx_take && !is_setup) begin
        rx_count <= rx_cnt;
        toggle   <= ~i_rx_data1;
        if (pp) begin
          rx_bank <= ~rx_bank;
        end
      end
      if (pp && ((rd_bank == 1'b0 && clr_rx0) || (rd_bank == 1'b1 && clr_rx1))) begin
        rd_bank <= ~rd_bank;
        rd_ptr  <= {AW{1'b0}};
      end else if ((clr_rx0 || clr_rx1) || (wr_st && !i_wdata[`UETE_S_SETUP])) begin
        rd_ptr  <= {AW{1'b0}};
      end else if (pop) begin
        rd_ptr  <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (rx_done && iso && bank_free) begin
        stall_crc <= ~i_rx_crc_ok;
      end else if (hs_stall) begin
        stall_crc <= 1'b1;
      end else if (wr_st && !i_wdata[`UETE_S_STALL_OR_CRC_FLAG]) begin
        stall_crc <= 1'b0;
      end
      if (wr_st && !i_wdata[`UETE_S_SETUP]) begin
        setup_flag <= 1'b0;
      end
      if (wr_st) begin
        stall_rq <= i_wdata[`UETE_S_STALL_REQUEST];
        dir      <= i_wdata[`UETE_S_DIR];
      end
      // Transmit side: ready set locks the bank length and moves firmware on.
      if (rdy_set) begin
        tx_rdy[wr_bank] <= 1'b1;
        tx_len[wr_bank] <= wr_cnt;
        wr_cnt          <= {CW{1'b0}};
        if (pp) begin
          wr_bank <= ~wr_bank;
        end
      end else if (wr_st && !i_wdata[`UETE_S_TX_PACKET_READY] && (state != ST_TX)) begin
        tx_rdy <= 2'b00;
        wr_cnt <= {CW{1'b0}};
        wr_bank <= tx_bank;
      end else if (push && (wr_cnt < DEPTH)) begin
        wr_cnt <= wr_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
      if (in_done) begin
        tx_rdy[tx_bank] <= 1'b0;
        tx_tog          <= ~tx_tog;
        if (pp) begin
          tx_bank <= ~tx_bank;
        end
      end
      tx_done <= in_done | (tx_done & ~(wr_st && !i_wdata[`UETE_S_TXDONE]));
      nak_in  <= nak_i | (nak_in & ~(wr_nak && !i_wdata[`UETE_N_NAK_IN_FLAG]));
      nak_out <= nak_o | (nak_out & ~(wr_nak && !i_wdata[`UETE_N_NAK_OUT_FLAG]));
      if (i_wr && (i_addr == `UETE_A_CTRL)) begin
        ctrl <= i_wdata[3:0];
      end
      if (i_wr && (i_addr == `UETE_A_EP_IE)) begin
        ep_ie <= i_wdata[6:0];
      end
    end
  end

  // ========================================================================
  // Frame tracking and global events
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      glob    <= 4'h0;
      glob_ie <= 2'b00;
      frame   <= 11'h000;
    end else begin
      if (i_bus_reset_end) begin
        glob[`UETE_G_EOR] <= 1'b1;
      end else if (wr_gl && !i_wdata[`UETE_G_EOR]) begin
        glob[`UETE_G_EOR] <= 1'b0;
      end
      if (i_bus_reset_end) begin
        glob[`UETE_G_SOF]    <= 1'b0;
        glob[`UETE_G_FRAME_CRC_GOOD]  <= 1'b0;
        glob[`UETE_G_CRCBAD] <= 1'b0;
        frame                <= 11'h000;
      end else if (i_sof) begin
        glob[`UETE_G_SOF]    <= 1'b1;
        glob[`UETE_G_FRAME_CRC_GOOD]  <= i_sof_crc_ok;
        glob[`UETE_G_CRCBAD] <= ~i_sof_crc_ok;
        frame                <= i_frame_num;
      end else if (wr_gl && !i_wdata[`UETE_G_SOF]) begin
        glob[`UETE_G_SOF] <= 1'b0;
      end
      if (i_wr && (i_addr == `UETE_A_GLOB_IE)) begin
        glob_ie <= i_wdata[1:0];
      end
    end
  end

  // ========================================================================
  // Interrupt request: level, held while any enabled flag is pending
  wire [6:0] ep_ev = {rx_full[1], stall_crc, nak_out, nak_in, setup_flag, tx_done, rx_full[0]};
  assign o_usb_irq = |(ep_ev & ep_ie) |
                     |(glob[1:0] & glob_ie);

  // ========================================================================
  // Register read port
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata <= `UETE_RST_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        `UETE_A_CTRL:     o_rdata <= {4'h0, ctrl};
        `UETE_A_STATUS:   o_rdata <= {dir, rx_full[1], stall_crc, tx_rdy[wr_bank],
                                      stall_rq, setup_flag, tx_done, rx_full[0]};
        `UETE_A_NAKTOG:   o_rdata <= {5'h00, toggle, nak_out, nak_in};
        `UETE_A_CNT_LO:   o_rdata <= rx_count[7:0];
        `UETE_A_CNT_HI:   o_rdata <= {5'h00, rx_count[CW-1:8]};
        `UETE_A_FIFO:     o_rdata <= rx_mem[{rd_bank, rd_ptr}];
        `UETE_A_EP_IE:    o_rdata <= {1'b0, ep_ie};
        `UETE_A_GLOBAL:   o_rdata <= {4'h0, glob};
        `UETE_A_GLOB_IE:  o_rdata <= {6'h00, glob_ie};
        `UETE_A_FRAME_LO: o_rdata <= frame[7:0];
        `UETE_A_FRAME_HI: o_rdata <= {5'h00, frame[10:8]};
        default:          o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // uete_endpoint

// ==== verification/uete_properties.sv ====
// Checker for the endpoint transaction engine, seeing only its ports.
`timescale 1ns/1ps
`include "uete_consts.vh"
module uete_properties (
  input wire        i_clk_sys,       // Clock.
  input wire        i_reset,         // Reset.
  input wire [3:0]  i_addr,          // Address.
  input wire [7:0]  i_wdata,         // Write data.
  input wire        i_wr,            // Write strobe.
  input wire        i_rd,            // Read strobe.
  input wire [7:0]  o_rdata,         // Read data.
  input wire        i_tok_valid,     // Token.
  input wire [3:0]  i_tok_pid,       // Token kind.
  input wire        i_rx_end,        // Packet end.
  input wire        i_sof,           // Frame start.
  input wire [10:0] i_frame_num,     // Frame number.
  input wire        i_bus_reset_end, // Bus reset over.
  input wire        i_tx_ready,      // Byte taken.
  input wire        o_hs_valid,      // Handshake.
  input wire        o_tx_valid,      // Byte offered.
  input wire [7:0]  o_tx_byte,       // Offered byte.
  input wire        o_usb_irq        // Interrupt.
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // ==========================================================================
  // Shadow of the mode and enable bits the rules depend on
  logic iso;
  logic sof_en;
  logic eor_en;
  always @(posedge i_clk_sys) begin
    if (i_reset || i_bus_reset_end)
      iso <= 1'b0;
    else if (i_wr && i_addr == `UETE_A_CTRL)
      iso <= i_wdata[`UETE_C_ISO];
    // The enable register outlives a bus reset, so only i_reset clears it.
    if (i_reset)
      {sof_en, eor_en} <= 2'b00;
    else if (i_wr && i_addr == `UETE_A_GLOB_IE)
      {sof_en, eor_en} <= {i_wdata[`UETE_G_SOF], i_wdata[`UETE_G_EOR]};
  end
  // ==========================================================================
  // Properties
  sequence s_sof_rd;
    i_sof && !i_bus_reset_end ##1 !i_sof && !i_bus_reset_end
      ##1 i_rd && i_addr == `UETE_A_FRAME_LO;
  endsequence
  a_iso_in_quiet: assert property (iso && i_tok_valid && i_tok_pid == `UETE_PID_IN
    |=> !o_hs_valid) else $error("handshake sent to isochronous IN");
  a_iso_no_hs: assert property (iso && i_rx_end |=> !o_hs_valid)
    else $error("handshake sent after isochronous OUT");
  a_eor_irq: assert property (i_bus_reset_end && eor_en && !i_wr |=> o_usb_irq)
    else $error("no interrupt after bus reset");
  a_sof_irq: assert property (i_sof && sof_en && !i_wr && !i_bus_reset_end
    |=> o_usb_irq) else $error("no interrupt after frame start");
  a_frame_capture: assert property (s_sof_rd |=> o_rdata == $past(i_frame_num[7:0], 3))
    else $error("frame number not captured");
  a_tx_after_in: assert property ($rose(o_tx_valid)
    |-> $past(i_tok_valid && i_tok_pid == `UETE_PID_IN)) else $error("data without IN");
  a_tx_hold: assert property (o_tx_valid && !i_tx_ready && !i_tok_valid && !i_wr
    && !i_bus_reset_end |=> o_tx_valid && $stable(o_tx_byte)) else $error("byte dropped");
  a_hs_cause: assert property (o_hs_valid |-> $past(i_rx_end) || $past(i_tok_valid))
    else $error("handshake without a cause");
endmodule // uete_properties

// ==== verification/uete_host_model.sv ====
// Model of the host controller on the full-speed bus side.
`timescale 1ns/1ps
module uete_host_model (
  input  wire         i_clk_sys,       // Clock.
  input  wire         o_hs_valid,      // Handshake.
  input  wire  [1:0]  o_hs_code,       // Handshake kind.
  input  wire         o_tx_valid,      // Byte offered.
  input  wire  [7:0]  o_tx_byte,       // Offered byte.
  input  wire         o_tx_last,       // Last byte.
  input  wire         o_tx_data1,      // DATA1 flag.
  output logic        i_tok_valid,     // Token.
  output logic [3:0]  i_tok_pid,       // Token kind.
  output logic        i_rx_valid,      // Data byte.
  output logic [7:0]  i_rx_byte,       // Byte value.
  output logic        i_rx_end,        // Packet end.
  output logic        i_rx_crc_ok,     // CRC good.
  output logic        i_rx_data1,      // DATA1.
  output logic        i_sof,           // Frame start.
  output logic [10:0] i_frame_num,     // Frame number.
  output logic        i_sof_crc_ok,    // Frame CRC good.
  output logic        i_bus_reset_end, // Bus reset over.
  output logic        i_host_ack,      // Host ACK.
  output logic        i_tx_ready       // Byte taken.
);
  logic [7:0] q[$];
  logic [7:0] got[$];
  logic [1:0] hs[$];
  int         nlast, nd1;
  initial begin
    {i_tok_valid, i_rx_valid, i_rx_end, i_sof, i_bus_reset_end} = 5'h00;
    {i_tok_pid, i_rx_byte, i_frame_num} = 23'h000000;
    {i_rx_crc_ok, i_rx_data1, i_sof_crc_ok, i_host_ack, i_tx_ready} = 5'h00;
  end
  // The receiver stalls at random so an offered byte has to stand.
  always @(posedge i_clk_sys) begin
    i_tx_ready <= 1'($urandom_range(1));
    if (o_tx_valid && i_tx_ready)
      got.push_back(o_tx_byte);
    if (o_tx_valid && i_tx_ready && o_tx_last)
      nlast++;
    if (o_tx_valid && o_tx_data1)
      nd1++;
    if (o_hs_valid)
      hs.push_back(o_hs_code);
  end
  task automatic token(input logic [3:0] pid);
    @(posedge i_clk_sys);
    i_tok_valid <= 1'b1;
    i_tok_pid <= pid;
    @(posedge i_clk_sys);
    i_tok_valid <= 1'b0;
    i_tok_pid <= ~pid;
  endtask
  task automatic out_pkt(input logic [3:0] pid, input logic crc, input logic d1);
    token(pid);
    foreach (q[k]) begin
      i_rx_valid <= 1'b1;
      i_rx_byte <= q[k];
      @(posedge i_clk_sys);
    end
    i_rx_valid <= 1'b0;
    i_rx_byte <= ~i_rx_byte;
    i_rx_end <= 1'b1;
    i_rx_crc_ok <= crc;
    i_rx_data1 <= d1;
    @(posedge i_clk_sys);
    i_rx_end <= 1'b0;
    i_rx_crc_ok <= ~crc;
  endtask
  task automatic sof(input logic [10:0] fn, input logic crc);
    @(posedge i_clk_sys);
    i_sof <= 1'b1;
    i_frame_num <= fn;
    i_sof_crc_ok <= crc;
    @(posedge i_clk_sys);
    i_sof <= 1'b0;
    i_frame_num <= ~fn;
  endtask
  task automatic bus_reset();
    @(posedge i_clk_sys);
    i_bus_reset_end <= 1'b1;
    @(posedge i_clk_sys);
    i_bus_reset_end <= 1'b0;
  endtask
endmodule // uete_host_model

// ==== verification/uete_endpoint_tb.sv ====
// Self-checking bench for the endpoint transaction engine.
`timescale 1ns/1ps
`include "uete_consts.vh"
module uete_endpoint_tb;
  logic        i_clk_sys, i_reset, i_wr, i_rd;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata;
  wire  [7:0]  o_rdata, o_tx_byte, i_rx_byte;
  wire  [1:0]  o_hs_code;
  wire  [3:0]  i_tok_pid;
  wire  [10:0] i_frame_num;
  wire o_hs_valid, o_tx_valid, o_tx_last, o_tx_empty, o_tx_data1, o_usb_irq;
  wire i_tok_valid, i_rx_valid, i_rx_end, i_rx_crc_ok, i_rx_data1, i_sof;
  wire i_sof_crc_ok, i_bus_reset_end, i_host_ack, i_tx_ready;
  int          err_total, checks, n;
  logic        bad;
  logic [10:0] fn;
  logic [7:0]  e[$];
  uete_endpoint DUT (.*);
  uete_host_model h (.*);
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] y);
    checks++;
    if (y !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] x, input string s,
                    input logic [7:0] m = 8'hff);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(s, x, o_rdata & m);
  endtask
  task automatic fill(input int len);
    h.q.delete();
    repeat (len) h.q.push_back(8'($urandom));
  endtask
  function automatic int stored(input int len);
    return (len > 64) ? 64 : len;
  endfunction
  function automatic logic [7:0] glob_exp(input logic ok);
    return ok ? 8'h05 : 8'h09;
  endfunction
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_total++;
    report_and_stop();
  end
  initial begin
    i_reset = 1'b1;
    {i_addr, i_wdata, i_wr, i_rd} = 14'h0000;
    void'($urandom(32'h1f8565c3));
    repeat (16) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    wr(`UETE_A_CTRL, 8'h03);
    wr(`UETE_A_EP_IE, 8'h43);
    wr(`UETE_A_GLOB_IE, 8'h03);
    // Empty, oversized and random packets, each followed by one that must be lost.
    for (int t = 0; t < 3; t++) begin
      n = (t == 0) ? 0 : (t == 1) ? 70 : $urandom_range(63, 1);
      bad = 1'($urandom_range(1));
      fill(n);
      e = h.q;
      h.out_pkt(`UETE_PID_OUT, ~bad, 1'b0);
      fill(n);
      h.out_pkt(`UETE_PID_OUT, ~bad, 1'b1);
      rc(`UETE_A_STATUS, {2'b00, bad, 5'h01}, "status");
      chk("irq", 8'h01, {7'h00, o_usb_irq});
      rc(`UETE_A_CNT_LO, n[7:0], "count");
      for (int k = 0; k < stored(n); k++) rc(`UETE_A_FIFO, e[k], "fifo");
      wr(`UETE_A_STATUS, 8'h00);
    end
    $display("test iso out done");
    wr(`UETE_A_CTRL, 8'h07);
    fill(5);
    e = h.q;
    h.out_pkt(`UETE_PID_OUT, 1'b1, 1'b0);
    fill(6);
    h.out_pkt(`UETE_PID_OUT, 1'b1, 1'b0);
    rc(`UETE_A_STATUS, 8'h41, "both banks");
    foreach (e[k]) rc(`UETE_A_FIFO, e[k], "bank0");
    e = h.q;
    wr(`UETE_A_STATUS, 8'h40);
    foreach (e[k]) rc(`UETE_A_FIFO, e[k], "bank1");
    wr(`UETE_A_STATUS, 8'h00);
    h.token(`UETE_PID_IN);
    repeat (8) @(posedge i_clk_sys);
    chk("idle in", 8'h00, 8'(h.got.size()));
    fill(7);
    e = h.q;
    for (int k = 0; k < 7; k++) begin
      wr(`UETE_A_FIFO, e[k]);
      if (k == 3 || k == 6)
        wr(`UETE_A_STATUS, 8'h10);
    end
    for (int p = 4; p <= 7; p += 3) begin
      h.token(`UETE_PID_IN);
      for (int w = 0; w < 200 && h.got.size() < p; w++) @(posedge i_clk_sys);
    end
    foreach (e[k]) chk("sent", e[k], h.got[k]);
    rc(`UETE_A_STATUS, 8'h02, "tx done");
    chk("packets", 8'h02, 8'(h.nlast));
    chk("iso data1", 8'h00, 8'(h.nd1));
    $display("test ping pong done");
    wr(`UETE_A_STATUS, 8'h00);
    wr(`UETE_A_FIFO_RST, 8'h00);
    wr(`UETE_A_CTRL, 8'h09);
    wr(`UETE_A_STATUS, 8'h08);
    h.token(`UETE_PID_IN);
    rc(`UETE_A_STATUS, 8'h28, "stall");
    chk("hs stall", {6'h00, `UETE_HS_STALL}, {6'h00, h.hs[0]});
    fill(8);
    h.out_pkt(`UETE_PID_SETUP, 1'b1, 1'b0);
    rc(`UETE_A_STATUS, 8'h04, "setup");
    rc(`UETE_A_NAKTOG, 8'h04, "toggle");
    wr(`UETE_A_STATUS, 8'h00);
    h.token(`UETE_PID_IN);
    rc(`UETE_A_NAKTOG, 8'h05, "nak in");
    fill(2);
    h.out_pkt(`UETE_PID_OUT, 1'b1, 1'b1);
    rc(`UETE_A_NAKTOG, 8'h00, "toggle", 8'h04);
    h.out_pkt(`UETE_PID_OUT, 1'b1, 1'b0);
    rc(`UETE_A_NAKTOG, 8'h03, "nak out");
    wr(`UETE_A_FIFO_RST, 8'h00);
    h.out_pkt(`UETE_PID_OUT, 1'b1, 1'b0);
    rc(`UETE_A_NAKTOG, 8'h04, "toggle", 8'h04);
    wr(`UETE_A_FIFO_RST, 8'h00);
    rc(`UETE_A_NAKTOG, 8'h00, "toggle", 8'h04);
    $display("test control done");
    for (int t = 0; t < 2; t++) begin
      fn = 11'($urandom);
      h.sof(fn, t == 0);
      rc(`UETE_A_FRAME_LO, fn[7:0], "frame lo");
      rc(`UETE_A_FRAME_HI, {5'h00, fn[10:8]}, "frame hi");
      rc(`UETE_A_GLOBAL, glob_exp(t == 0), "global");
      chk("irq", 8'h01, {7'h00, o_usb_irq});
      wr(`UETE_A_GLOBAL, 8'h00);
    end
    h.bus_reset();
    rc(`UETE_A_GLOBAL, 8'h02, "bus reset");
    rc(`UETE_A_CTRL, 8'h00, "ctrl");
    chk("irq", 8'h01, {7'h00, o_usb_irq});
    wr(`UETE_A_GLOBAL, 8'h00);
    rc(`UETE_A_GLOBAL, 8'h00, "global");
    chk("irq", 8'h00, {7'h00, o_usb_irq});
    $display("test frame and reset done");
    report_and_stop();
  end
endmodule // uete_endpoint_tb
bind uete_endpoint uete_properties u_props (.*);
